// ---- fpt_checker.sv ----
////////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: the register addresses and the APB slave port.
module fpt_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic line_p,
   input wire logic line_n,
   input wire logic ac_activate,
   input wire logic tx_release,
   output logic rx_strobe_o,
   output logic req_start_o,
   output logic tx_on_o,
   output logic pport_strobe_o,
   output logic pport_oe_o,
   output logic irq_o
);
   ////////////////////////////////////////////////////////////////////////////
   fpt_pkg::fpt_state_t st_q, st_d;
   logic p_lvl, n_lvl, p_rise_raw, n_rise_raw;
   logic [6:0] ph_q;
   logic [4:0] hb_q, last_slot_q, slot_w, end_slot_w;
   logic [8:0] tail_q, idle_q, len_lim_w;
   logic last_pos_q, mid_seen_q, par_q, sync_q, ac_q, tx_on_q, strobe_q;
   logic [fpt_pkg::DATA_W-1:0] sr_q, data_q;
   logic [fpt_pkg::CTRL_W-1:0] ctrl_q;
   logic [fpt_pkg::N_ERR:0] irq_sts_q, irq_mask_q, ev_w;
   logic [fpt_pkg::N_ERR-1:0] err_w;
   logic [31:0] rd_w, prdata_q;
   fpt_pkg::fpt_mode_t mode_w;
   logic rsp_w, line_en, p_rise, n_rise, edge_w, act_w, in_early, in_late;
   logic mid_chk, even_slot, at_end, len_done, any_err, good_w, slave_w;
   logic addr_match, wr_acc, rd_setup, sel_ctrl, sel_stat, sel_data;
   logic sel_sts, sel_mask, mapped;

   ////////////////////////////////////////////////////////////////////////////
   // separate pulse paths
   // one filter per polarity keeps the two comparator outputs apart
   fpt_pulse_filter u_filt_p (
      .pclk(pclk),
      .presetn(presetn),
      .pulse_in(line_p),
      .lvl_o(p_lvl),
      .rise_o(p_rise_raw)
   );
   fpt_pulse_filter u_filt_n (
      .pclk(pclk),
      .presetn(presetn),
      .pulse_in(line_n),
      .lvl_o(n_lvl),
      .rise_o(n_rise_raw)
   );

   // control fields and line gating
   assign mode_w = fpt_pkg::fpt_mode_t'(ctrl_q[fpt_pkg::CTRL_MODE_LSB +: 2]);
   assign rsp_w = ctrl_q[fpt_pkg::CTRL_RSP_BIT];
   assign slave_w = (mode_w == fpt_pkg::FPT_SLAVE);
   assign line_en = !(ac_q && slave_w);
   assign p_rise = p_rise_raw && line_en;
   assign n_rise = n_rise_raw && line_en;
   assign edge_w = p_rise || n_rise;
   assign act_w = (p_lvl || n_lvl) && line_en;

   // grid slot of a pulse
   // late part of the current slot, or early part of the next one
   assign in_late = (ph_q <= 7'(fpt_pkg::LATE_CYC));
   assign in_early = (ph_q >= 7'(fpt_pkg::HALF_CYC - fpt_pkg::EARLY_CYC));
   assign slot_w = in_late ? hb_q : hb_q + 5'h01;
   assign even_slot = !slot_w[0];
   assign end_slot_w = rsp_w ? fpt_pkg::END_SLOT_RSP : fpt_pkg::END_SLOT_REQ;
   assign at_end = edge_w && (slot_w == end_slot_w) && (in_late || in_early);
   // mid-bit check point just past the late edge of an even slot
   assign mid_chk = (ph_q == 7'(fpt_pkg::LATE_CYC + 1)) && !hb_q[0]
                    && (hb_q != 5'h00) && (hb_q <= end_slot_w);

   // length window, longer for requests while not synchronised
   assign len_lim_w = (!rsp_w && !sync_q) ? 9'(fpt_pkg::LEN_ASYNC_CYC)
                                          : 9'(fpt_pkg::LEN_SYNC_CYC);
   assign len_done = (tail_q == len_lim_w);

   // error detection per state
   always_comb begin
      err_w = '0;
      unique case (st_q)
         fpt_pkg::FPT_IDLE: begin
            err_w[fpt_pkg::E_START] = p_rise;
         end
         fpt_pkg::FPT_RECV: begin
            err_w[fpt_pkg::E_ALT] = (p_rise && last_pos_q) || (n_rise && !last_pos_q)
                                    || (p_rise && n_rise);
            // off grid, repeated slot or past the last slot
            err_w[fpt_pkg::E_TIM] = edge_w && (!(in_late || in_early)
                                    || (slot_w <= last_slot_q) || (slot_w > end_slot_w));
            err_w[fpt_pkg::E_INFO] = mid_chk && !mid_seen_q;
            err_w[fpt_pkg::E_END] = at_end && !p_rise;
            // even sum of information and parity bits
            err_w[fpt_pkg::E_PAR] = at_end && par_q;
         end
         fpt_pkg::FPT_TAIL: begin
            // a new pulse after the end pulse; its own level is still high here
            err_w[fpt_pkg::E_LEN] = edge_w;
         end
         fpt_pkg::FPT_WAIT: begin
            err_w = '0;
         end
      endcase
   end
   assign any_err = |err_w;
   assign good_w = (st_q == fpt_pkg::FPT_TAIL) && len_done && !edge_w && line_en;

   // next state
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         fpt_pkg::FPT_IDLE: begin
            if (n_rise && !p_rise) begin
               st_d = fpt_pkg::FPT_RECV;
            end
         end
         fpt_pkg::FPT_RECV: begin
            if (at_end) begin
               st_d = fpt_pkg::FPT_TAIL;
            end
         end
         fpt_pkg::FPT_TAIL: begin
            if (good_w) begin
               st_d = fpt_pkg::FPT_IDLE;
            end
         end
         fpt_pkg::FPT_WAIT: begin
            // leave only after a full pause
            if ((idle_q == 9'(fpt_pkg::PAUSE_CYC)) && !act_w) begin
               st_d = fpt_pkg::FPT_IDLE;
            end
         end
      endcase
      // any fault drops the telegram and waits for a pause
      if (any_err) begin
         st_d = fpt_pkg::FPT_WAIT;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= fpt_pkg::FPT_WAIT;
      end else begin
         st_q <= st_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // grid counters restart on the leading negative pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ph_q <= 7'h00;
         hb_q <= 5'h00;
      end else if (st_q != fpt_pkg::FPT_RECV) begin
         ph_q <= 7'h01; // the cycle of the leading pulse itself was phase 0
         hb_q <= 5'h00;
      end else if (ph_q == 7'(fpt_pkg::HALF_CYC - 1)) begin
         ph_q <= 7'h00;
         hb_q <= (hb_q == fpt_pkg::SLOT_MAX) ? hb_q : hb_q + 5'h01;
      end else begin
         ph_q <= ph_q + 7'h01;
      end
   end

   // per-pulse tracking: polarity, slot, mid-bit seen, bits and parity
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_pos_q <= 1'b0;
         last_slot_q <= 5'h00;
         mid_seen_q <= 1'b0;
         par_q <= 1'b0;
         sr_q <= '0;
      end else if (st_q == fpt_pkg::FPT_IDLE) begin
         // start pulse is slot 0 and decodes as the zero start bit
         last_pos_q <= 1'b0;
         last_slot_q <= 5'h00;
         mid_seen_q <= 1'b0;
         par_q <= 1'b0;
         sr_q <= '0;
      end else if (st_q == fpt_pkg::FPT_RECV) begin
         if (edge_w) begin
            last_pos_q <= p_rise;
            last_slot_q <= slot_w;
            if (even_slot) begin
               // mid-bit pulse: positive is one, negative is zero
               mid_seen_q <= 1'b1;
               sr_q <= {sr_q[fpt_pkg::DATA_W-2:0], p_rise};
               if (slot_w != end_slot_w) begin
                  par_q <= par_q ^ p_rise;
               end
            end
         end else if (mid_chk) begin
            mid_seen_q <= 1'b0;
         end
      end
   end

   // length window and pause timers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tail_q <= 9'h000;
         idle_q <= 9'h000;
      end else begin
         tail_q <= (st_q == fpt_pkg::FPT_TAIL) ? tail_q + 9'h001 : 9'h000;
         // pause is a run of cycles with no filtered activity
         idle_q <= (st_q != fpt_pkg::FPT_WAIT || act_w) ? 9'h000 : idle_q + 9'h001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave address sits in bits 11..7 of a request, after start and control bits
   assign addr_match = (sr_q[fpt_pkg::DATA_W-3 -: 5] == ctrl_q[fpt_pkg::CTRL_ADDR_LSB +: 5]);

   // strobe, sync state, transmitter, channel latch and received word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strobe_q <= 1'b0;
         sync_q <= 1'b0;
         tx_on_q <= 1'b0;
         ac_q <= 1'b0;
         data_q <= '0;
      end else begin
         strobe_q <= good_w;
         if (ac_activate && slave_w) begin
            ac_q <= 1'b1;
         end
         if (good_w) begin
            data_q <= sr_q;
         end
         // a fault leaves the receiver asynchronous
         if (any_err) begin
            sync_q <= 1'b0;
         end else if (good_w && !rsp_w) begin
            sync_q <= 1'b1;
         end
         // transmitter on with the strobe when addressed
         if (good_w && !rsp_w && slave_w && addr_match) begin
            tx_on_q <= 1'b1;
         end else if (tx_release) begin
            tx_on_q <= 1'b0;
         end
      end
   end

   assign rx_strobe_o = strobe_q;
   // master strobe starts request processing in slave mode
   assign req_start_o = strobe_q && slave_w && !rsp_w;
   assign tx_on_o = tx_on_q;
   // strobe shown on parameter port in master and monitor modes
   assign pport_oe_o = (mode_w == fpt_pkg::FPT_MASTER) || (mode_w == fpt_pkg::FPT_MONITOR);
   assign pport_strobe_o = strobe_q && pport_oe_o;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode; answers in the access cycle with no wait states
   assign sel_ctrl = (paddr == fpt_pkg::OFS_CTRL);
   assign sel_stat = (paddr == fpt_pkg::OFS_STAT);
   assign sel_data = (paddr == fpt_pkg::OFS_DATA);
   assign sel_sts = (paddr == fpt_pkg::OFS_IRQ_STS);
   assign sel_mask = (paddr == fpt_pkg::OFS_IRQ_MASK);
   assign mapped = sel_ctrl || sel_stat || sel_data || sel_sts || sel_mask;
   assign wr_acc = psel && penable && pwrite && mapped;
   assign rd_setup = psel && !penable && !pwrite;
   assign rd_w = sel_ctrl ? 32'(ctrl_q)
               : sel_stat ? {27'h0000000, ac_q, tx_on_q, sync_q, st_q}
               : sel_data ? 32'(data_q)
               : sel_sts ? 32'(irq_sts_q)
               : sel_mask ? 32'(irq_mask_q)
               : 32'h00000000;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_q;

   // events: bit 0 strobe, bits above the individual faults
   assign ev_w = {err_w, good_w};

   // registers; a new event wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= fpt_pkg::CTRL_RST;
         irq_sts_q <= '0;
         irq_mask_q <= '0;
         prdata_q <= 32'h00000000;
      end else begin
         if (wr_acc && sel_ctrl) begin
            ctrl_q <= pwdata[fpt_pkg::CTRL_W-1:0];
         end
         if (wr_acc && sel_mask) begin
            irq_mask_q <= pwdata[fpt_pkg::N_ERR:0];
         end
         irq_sts_q <= (irq_sts_q & ~((wr_acc && sel_sts) ? pwdata[fpt_pkg::N_ERR:0] : '0))
                      | ev_w;
         if (rd_setup) begin
            prdata_q <= rd_w;
         end
      end
   end

   assign irq_o = |(irq_sts_q & irq_mask_q);

   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_fault;
      any_err;
   endsequence
   sequence s_async_wait;
      st_q == fpt_pkg::FPT_WAIT && !sync_q && !strobe_q;
   endsequence

   a_start_polarity: assert property ((st_q == fpt_pkg::FPT_IDLE && p_rise) |=> st_q == fpt_pkg::FPT_WAIT)
      else $error("positive leading pulse did not fault");
   a_alternation: assert property ((st_q == fpt_pkg::FPT_RECV && p_rise && last_pos_q) |-> err_w[fpt_pkg::E_ALT])
      else $error("repeated positive pulse not flagged");
   a_grid_window: assert property ((st_q == fpt_pkg::FPT_RECV && edge_w && ph_q == 7'(fpt_pkg::LATE_CYC + 1)) |-> err_w[fpt_pkg::E_TIM])
      else $error("off-grid pulse not flagged");
   a_fault_async: assert property (s_fault |=> s_async_wait)
      else $error("fault did not force asynchronous wait");
   a_pause_needed: assert property ((st_q == fpt_pkg::FPT_WAIT && act_w) |=> st_q == fpt_pkg::FPT_WAIT [*2])
      else $error("left wait state during line activity");
   a_strobe_sync: assert property ((good_w && !rsp_w) |=> sync_q && strobe_q)
      else $error("master strobe did not synchronise");
   a_pport_strobe: assert property ((strobe_q && mode_w == fpt_pkg::FPT_MONITOR) |-> pport_strobe_o && pport_oe_o)
      else $error("monitor mode strobe missing on parameter port");
   a_req_start: assert property (req_start_o |-> $past(good_w) && slave_w)
      else $error("request start without a master strobe");
   a_tx_turn_on: assert property ((good_w && !rsp_w && slave_w && addr_match) |=> tx_on_o)
      else $error("transmitter not turned on for own address");
   a_ac_ignore: assert property ((ac_q && slave_w) |-> !edge_w && !strobe_q ##1 !strobe_q)
      else $error("line accepted while addressing channel active");
endmodule

// ---- fpt_pkg.sv ----
package fpt_pkg;
   // clock and timing, in nanoseconds as specified, then derived cycle counts
   localparam int CLK_NS = 40;
   localparam int FILT_NS = 750;
   localparam int HALF_NS = 3000;
   localparam int EARLY_NS = 875;
   localparam int LATE_NS = 1500;
   localparam int BIT_NS = 6000;
   localparam int PAUSE_BITS = 3;
   // least time rounds up
   localparam int FILT_CYC = (FILT_NS + CLK_NS - 1) / CLK_NS;
   // grid period and tolerance edges; longest times round down
   localparam int HALF_CYC = HALF_NS / CLK_NS;
   localparam int EARLY_CYC = EARLY_NS / CLK_NS;
   localparam int LATE_CYC = LATE_NS / CLK_NS;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam int PAUSE_CYC = PAUSE_BITS * BIT_CYC;
   localparam int LEN_SYNC_CYC = BIT_CYC;
   localparam int LEN_ASYNC_CYC = 3 * BIT_CYC;

   // half-bit slot of the end pulse, and telegram bit counts
   localparam logic [4:0] END_SLOT_REQ = 5'h1A;
   localparam logic [4:0] END_SLOT_RSP = 5'h0C;
   localparam logic [4:0] SLOT_MAX = 5'h1E;
   localparam int DATA_W = 14;

   // operating modes
   typedef enum logic [1:0] {
      FPT_SLAVE = 2'h0,
      FPT_MASTER = 2'h1,
      FPT_REPEATER = 2'h2,
      FPT_MONITOR = 2'h3
   } fpt_mode_t;

   // receiver states, gray along idle-recv-tail and the error path except from recv
   typedef enum logic [1:0] {
      FPT_IDLE = 2'h0,
      FPT_RECV = 2'h1,
      FPT_TAIL = 2'h3,
      FPT_WAIT = 2'h2
   } fpt_state_t;

   // error bit positions; status bit 0 is the receive strobe
   localparam int E_START = 0;
   localparam int E_ALT = 1;
   localparam int E_TIM = 2;
   localparam int E_INFO = 3;
   localparam int E_PAR = 4;
   localparam int E_END = 5;
   localparam int E_LEN = 6;
   localparam int N_ERR = 7;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_IRQ_STS = 8'h0C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
   // control fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_RSP_BIT = 2;
   localparam int CTRL_ADDR_LSB = 3;
   localparam int CTRL_W = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
endpackage

// ---- fpt_pulse_filter.sv ----
module fpt_pulse_filter (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pulse_in,
   output logic lvl_o,
   output logic rise_o
);
   logic s1_q, s2_q, lvl_q;
   logic [4:0] cnt_q, cnt_d;

   // two-stage synchroniser, first stage read only by the second
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
      end else begin
         s1_q <= pulse_in;
         s2_q <= s1_q;
      end
   end

   // filter short activity
   // level only follows once it has stood still for the full filter time
   assign cnt_d = (s2_q == lvl_q) ? 5'h00 : cnt_q + 5'h01;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 5'h00;
         lvl_q <= 1'b0;
      end else if (cnt_d == 5'(fpt_pkg::FILT_CYC)) begin
         cnt_q <= 5'h00;
         lvl_q <= s2_q;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign lvl_o = lvl_q;
   // edge pulse fires as the filtered level rises; all pulses share the delay
   assign rise_o = (cnt_d == 5'(fpt_pkg::FILT_CYC)) && s2_q && !lvl_q;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_filter_width: assert property ($rose(lvl_q) |-> $past(s2_q, 1) && $past(cnt_q) == 5'(fpt_pkg::FILT_CYC - 1))
      else $error("filtered level rose without a full filter time");
endmodule

// ---- fpt_line_model.sv ----
module fpt_line_model (
   input wire logic pclk,
   output logic line_p,
   output logic line_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // half-bit slot and pulse width in cycles; width stays well clear of the next slot
   localparam int SLOT = fpt_pkg::HALF_CYC;
   localparam int WID = 30;
   int c = 0;

   // comparators idle low between pulses
   initial begin
      line_p = 1'b0;
      line_n = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // one pulse on one comparator line, entered just after a clock edge
   task automatic pulse(input logic pos, input int w);
      line_p <= pos;
      line_n <= !pos;
      repeat (w) @(posedge pclk);
      line_p <= 1'b0;
      line_n <= 1'b0;
   endtask

   // pulse at a half-bit slot, dropped or pushed 40 cycles late on request
   task automatic emit(input int s, input logic pos, input int skip, input int late);
      int t;
      t = s * SLOT + ((s == late) ? 40 : 0);
      if (s != skip) begin
         repeat (t - c) @(posedge pclk);
         pulse(pos, WID);
         c = t + WID;
      end
   endtask

   // telegram of n bits, first bit sent first; bit value is the mid-bit polarity
   task automatic send(input logic [13:0] w, input int n, input int skip, input int late);
      c = 0;
      for (int k = 0; k < n; k++) begin
         if (k > 0 && w[n-k] == w[n-1-k]) begin
            emit(2 * k - 1, !w[n-1-k], skip, late);
         end
         emit(2 * k, w[n-1-k], skip, late);
      end
   endtask
endmodule

// ---- fpt_checker_tb.sv ----
module fpt_checker_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // good request to address 0x0A, another address, and a slave response
   localparam logic [13:0] GOOD = {2'b00, 5'h0A, 5'h13, ^{5'h0A, 5'h13}, 1'b1};
   localparam logic [13:0] MISS = {2'b00, 5'h0B, 5'h13, ^{5'h0B, 5'h13}, 1'b1};
   localparam logic [13:0] RSP = {7'h00, 1'b0, 4'h5, ^4'h5, 1'b1};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic ac_activate = 1'b0;
   logic tx_release = 1'b0;
   logic [31:0] prdata;
   logic pready, pslverr, line_p, line_n, rx_strobe_o, req_start_o, tx_on_o;
   logic pport_strobe_o, pport_oe_o, irq_o, last_err;
   int err_count = 0;
   int checks_done = 0;
   int n_str = 0;
   int n_pp = 0;
   int n_rq = 0;
   int s_rq = 0;

   always #20 pclk = ~pclk;

   fpt_checker u_fpt_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .line_p(line_p), .line_n(line_n),
      .ac_activate(ac_activate), .tx_release(tx_release), .rx_strobe_o(rx_strobe_o),
      .req_start_o(req_start_o), .tx_on_o(tx_on_o), .pport_strobe_o(pport_strobe_o),
      .pport_oe_o(pport_oe_o), .irq_o(irq_o));
   fpt_line_model u_fpt_line_model (.pclk(pclk), .line_p(line_p), .line_n(line_n));

   // strobes are one cycle wide, so count them as they pass
   always @(posedge pclk) begin
      if (rx_strobe_o === 1'b1) n_str++;
      if (pport_strobe_o === 1'b1) n_pp++;
      if (req_start_o === 1'b1) n_rq++;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      if (err_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t ns: %s", $time, m);
      end
   endtask

   // one transfer; the request stands until pready is seen high at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         $display("wrong value at %0t ns: no pready", $time);
      end
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
      // the write lands at the access edge; let it settle before anything is judged
      @(posedge pclk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string m);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      chk(r, e, m);
   endtask

   // clear status, send, let window and a pause pass, then judge status and strobes
   task automatic frame(input logic [13:0] w, input int n, input int skip, input int late,
         input int ext, input logic [7:0] eb, input string m);
      logic [31:0] r;
      int s0;
      wr(fpt_pkg::OFS_IRQ_STS, 32'h0000_00FF);
      s0 = n_str;
      u_fpt_line_model.send(w, n, skip, late);
      if (ext > 0) begin
         repeat (ext) @(posedge pclk);
         u_fpt_line_model.pulse(1'b0, 30);
      end
      repeat (600) @(posedge pclk);
      apb(1'b0, fpt_pkg::OFS_IRQ_STS, 32'h0000_0000, r);
      chk(r & {24'h0, eb}, {24'h0, eb}, m);
      if (eb == 8'h01 || eb == 8'h00) chk(r, {24'h0, eb}, m);
      chk(32'(n_str - s0), {31'h0, eb[0]}, m);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // a hang still ends in the verdict
   initial begin
      repeat (80000) @(posedge pclk);
      err_count++;
      $display("wrong value at %0t ns: watchdog", $time);
      test_done();
   end

   // main sequence; spike precedes the first telegram so a leak would spoil it
   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(fpt_pkg::OFS_CTRL, 32'h0, "ctrl reset");
      rd_chk(fpt_pkg::OFS_STAT, 32'h2, "stat reset");
      rd_chk(8'h14, 32'h0, "unmapped read");
      chk({31'h0, last_err}, 32'h1, "unmapped error");
      wr(fpt_pkg::OFS_CTRL, 32'h1);
      wr(fpt_pkg::OFS_IRQ_MASK, 32'h1);
      repeat (500) @(posedge pclk);
      chk({31'h0, pport_oe_o}, 32'h1, "port enable");
      u_fpt_line_model.pulse(1'b0, 10);
      frame(GOOD, 14, -1, -1, 0, 8'h01, "good request");
      rd_chk(fpt_pkg::OFS_DATA, {18'h0, GOOD}, "data");
      chk(32'(n_pp), 32'(n_str), "port strobes");
      chk({31'h0, irq_o}, 32'h1, "irq raised");
      wr(fpt_pkg::OFS_IRQ_MASK, 32'h0);
      chk({31'h0, irq_o}, 32'h0, "irq masked");
      wr(fpt_pkg::OFS_IRQ_MASK, 32'h1);
      wr(fpt_pkg::OFS_IRQ_STS, 32'h1);
      chk({31'h0, irq_o}, 32'h0, "irq cleared");
      frame(GOOD | 14'h2000, 14, -1, -1, 0, 8'h02, "start");
      frame(GOOD, 14, 1, -1, 0, 8'h04, "alternation");
      frame(GOOD, 14, -1, 1, 0, 8'h08, "grid");
      frame(GOOD, 14, 2, -1, 0, 8'h10, "midbit");
      frame(GOOD ^ 14'h0002, 14, -1, -1, 0, 8'h20, "parity");
      frame(GOOD ^ 14'h0001, 14, -1, -1, 0, 8'h40, "end polarity");
      frame(GOOD, 14, -1, -1, 20, 8'h80, "length");
      u_fpt_line_model.send(GOOD | 14'h2000, 14, -1, -1);
      repeat (100) @(posedge pclk);
      frame(GOOD, 14, -1, -1, 0, 8'h00, "no pause");
      wr(fpt_pkg::OFS_CTRL, 32'h5);
      frame(RSP, 7, -1, -1, 0, 8'h01, "response");
      rd_chk(fpt_pkg::OFS_DATA, {25'h0, RSP[6:0]}, "response data");
      frame(RSP, 7, -1, -1, 20, 8'h80, "response length");
      wr(fpt_pkg::OFS_CTRL, 32'h3);
      frame(GOOD, 14, -1, -1, 0, 8'h01, "monitor");
      chk(32'(n_pp), 32'(n_str), "monitor strobes");
      wr(fpt_pkg::OFS_CTRL, 32'h2);
      frame(GOOD, 14, -1, -1, 0, 8'h01, "repeater");
      chk(32'(n_pp + 1), 32'(n_str), "repeater strobes");
      chk({31'h0, pport_oe_o}, 32'h0, "repeater enable");
      // slave mode, own address 0x0A
      wr(fpt_pkg::OFS_CTRL, 32'h50);
      s_rq = n_rq;
      frame(GOOD, 14, -1, -1, 0, 8'h01, "slave");
      chk(32'(n_rq - s_rq), 32'h1, "request start");
      chk({31'h0, tx_on_o}, 32'h1, "tx on");
      rd_chk(fpt_pkg::OFS_STAT, 32'h0C, "stat sync");
      tx_release <= 1'b1;
      @(posedge pclk);
      tx_release <= 1'b0;
      @(posedge pclk);
      chk({31'h0, tx_on_o}, 32'h0, "tx released");
      frame(MISS, 14, -1, -1, 0, 8'h01, "other address");
      chk({31'h0, tx_on_o}, 32'h0, "tx stays off");
      chk(32'(n_rq - s_rq), 32'h2, "request start 2");
      ac_activate <= 1'b1;
      @(posedge pclk);
      ac_activate <= 1'b0;
      frame(GOOD, 14, -1, -1, 0, 8'h00, "line ignored");
      test_done();
   end
endmodule
